/* File: bench/tlt_regs_test.sv */
// Purpose: self-checking bench for the tx length / trim register block
// Assumes: zero wait state slave, byte address = 4 * register index
// Notes: random data from a bench lfsr, corner values mixed in
`include "tlt_defs.svh"
module tlt_regs_test import tlt_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, restore_defaults, tx_start, iso_a_mode;
  logic anticoll_ctl, card_idle, wakeup_a_cmd, rate_valid, adc_valid, cal_valid, cal_error;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] rate_code, cal_trim, tg1, tg2;
  logic [7:0] adc_value, hi, lo;
  logic hreadyout, hresp, irq;
  wire hready;
  tlt_tx_cfg_s tx_cfg;
  int n_errors = 0;
  int total_checks = 0;
  assign hready = hreadyout;
  tlt_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .restore_defaults(restore_defaults),
    .tx_start(tx_start), .iso_a_mode(iso_a_mode), .anticoll_ctl(anticoll_ctl),
    .card_idle(card_idle), .wakeup_a_cmd(wakeup_a_cmd), .rate_valid(rate_valid),
    .rate_code(rate_code), .adc_valid(adc_valid), .adc_value(adc_value), .cal_valid(cal_valid),
    .cal_trim(cal_trim), .cal_error(cal_error), .tx_cfg(tx_cfg), .trim_pins_group_one(tg1),
    .trim_pins_group_two(tg2), .irq(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfg_exp(input logic [7:0] h, input logic [7:0] l, input logic a);
    return {14'h0, h, l[7:3], l[2:0], a & (l[2:0] != 3'h0), l[2:0] != 3'h0};
  endfunction
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge hclk);
  endtask
  // wait on hready with a bound; the bench never assumes the answer latency
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, {24'h0, d}, r);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(r, {24'h0, e});
  endtask
  // the mask is not a restore field, so its expected value is passed in
  task automatic all_zero(input logic [7:0] m);
    logic [7:0] t [9] = '{`TLT_IDX_CNT_HIGH, `TLT_IDX_CNT_LOW, `TLT_IDX_RATE, `TLT_IDX_ADC,
      `TLT_IDX_TRIM, `TLT_IDX_CAL_DISP, `TLT_IDX_IRQ_STAT, `TLT_IDX_IRQ_MASK, 8'h10};
    foreach (t[k]) rd(t[k], (t[k] == `TLT_IDX_IRQ_MASK) ? m : 8'h00);
    chk({31'h0, irq}, 32'h0);
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    #2_000_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, restore_defaults, tx_start, iso_a_mode, anticoll_ctl} = '0;
    {card_idle, wakeup_a_cmd, rate_valid, adc_valid, cal_valid, cal_error} = '0;
    {haddr, hwdata, htrans, rate_code, cal_trim, adc_value} = '0;
    hsize = 3'h2;
    seed = 32'h94b2;
    repeat (3) tick();
    hresetn <= 1'b1;
    all_zero(8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      {lo, hi} = seed[15:0];
      iso_a_mode <= seed[16];
      if (i == 0) {hi, lo} = 16'hffff;
      if (i == 1) lo[2:0] = 3'h0;
      wr(`TLT_IDX_CNT_HIGH, hi);
      wr(`TLT_IDX_CNT_LOW, lo);
      rd(`TLT_IDX_CNT_HIGH, hi);
      rd(`TLT_IDX_CNT_LOW, lo);
      tx_start <= 1'b1;
      tick();
      tx_start <= 1'b0;
      wr(`TLT_IDX_CNT_LOW, ~lo);
      chk(32'(tx_cfg), cfg_exp(hi, lo, iso_a_mode));
      seed = lfsr(seed);
      {rate_code, adc_value, cal_trim} <= seed[15:0];
      {rate_valid, adc_valid, cal_valid} <= 3'b111;
      tick();
      {rate_valid, adc_valid, cal_valid} <= 3'b000;
      wr(`TLT_IDX_RATE, 8'hff);
      rd(`TLT_IDX_RATE, {rate_code, 4'h0});
      rd(`TLT_IDX_ADC, adc_value);
      rd(`TLT_IDX_CAL_DISP, {cal_trim, 4'h0});
      wr(`TLT_IDX_TRIM, {1'b0, seed[19:16], 3'h7});
      #1 chk({tg1, tg2}, {cal_trim, cal_trim});
      wr(`TLT_IDX_TRIM, {1'b1, seed[19:16], 3'h7});
      #1 chk({tg1, tg2}, {seed[19:16], seed[19:16]});
      rd(`TLT_IDX_TRIM, {1'b1, seed[19:16], 3'h0});
    end
    // ----------------------------------------
    // interrupts, then restore defaults
    // ----------------------------------------
    wr(`TLT_IDX_IRQ_MASK, 8'h01);
    anticoll_ctl <= 1'b1;
    // pass 0: whole bytes only, pass 1: card not idle, pass 2: every condition met
    for (int s = 0; s < 3; s++) begin
      card_idle <= (s != 1);
      wr(`TLT_IDX_CNT_LOW, s ? 8'h05 : 8'h00);
      wakeup_a_cmd <= 1'b1;
      tick();
      wakeup_a_cmd <= 1'b0;
      tick();
      #1 chk({31'h0, irq}, {31'h0, s == 2});
      rd(`TLT_IDX_IRQ_STAT, {7'h0, s == 2});
    end
    {cal_error, cal_valid} <= 2'b11;
    tick();
    {cal_error, cal_valid} <= 2'b00;
    wr(`TLT_IDX_IRQ_STAT, 8'h01);
    #1 chk({31'h0, irq}, 32'h0);
    rd(`TLT_IDX_IRQ_STAT, 8'h02);
    rd(`TLT_IDX_CAL_DISP, {cal_trim, 4'h8});
    wr(`TLT_IDX_IRQ_STAT, 8'h02);
    restore_defaults <= 1'b1;
    tick();
    restore_defaults <= 1'b0;
    tick();
    all_zero(8'h01);
    wrap_up();
  end
endmodule

/* File: logic/tlt_regs.sv */
// Purpose: tx byte count, split bits, bit rate / adc display, antenna trim control
// Assumes: AHB-Lite single word transfers, zero wait states, always OKAY
// Notes: one-cycle restore-defaults pulse clears the count, trim and display registers, not the irq mask, status or tx snapshot
//
// Notes on behaviour
// - thirteen-bit full byte count, eight high bits then five low bits, up to 8191.
// - three-bit split count; zero means every transmitted byte is complete.
// - nonzero split count makes type A transmit a bit-oriented anticollision frame.
// - partial last byte means the frame goes out without parity bits.
// - anticollision bit, idle card, nonzero split, wake-up-A command raise parity interrupt.
// - detected active-mode bit rate shown read-only in upper nibble, lower nibble zero.
// - latest eight-bit converter result shown read-only.
// - trim select zero uses calibration result, one uses manual trim value.
// - manual trim bit one turns on transistor on both pin groups, bit 6 msb.
// - count and trim control registers reset to zero at power-up and restore-defaults.
// - bit rate and converter displays clear to zero at power-up and restore-defaults.
// - calibration result kept in its own display register, drives trims in auto mode.
//
// Chosen here: register access over AHB-Lite.
`include "tlt_defs.svh"
module tlt_regs
  import tlt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic restore_defaults,
  input wire logic tx_start,
  input wire logic iso_a_mode,
  input wire logic anticoll_ctl,
  input wire logic card_idle,
  input wire logic wakeup_a_cmd,
  input wire logic rate_valid,
  input wire logic [3:0] rate_code,
  input wire logic adc_valid,
  input wire logic [7:0] adc_value,
  input wire logic cal_valid,
  input wire logic [3:0] cal_trim,
  input wire logic cal_error,
  output tlt_tx_cfg_s tx_cfg,
  output logic [3:0] trim_pins_group_one,
  output logic [3:0] trim_pins_group_two,
  output logic irq
);
  // ----------------------------------------
  // bus capture
  // ----------------------------------------
  tlt_req_s req_reg, req_next;
  logic take;
  always_comb begin
    take = hsel & hready & htrans[1];
    req_next = '{sel: take, write: hwrite, index: haddr[9:2]};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] cnt_high_reg, cnt_high_next;
  logic [7:0] cnt_low_reg, cnt_low_next;
  logic [7:0] rate_reg, rate_next;
  logic [7:0] adc_reg, adc_next;
  logic [7:0] trim_reg, trim_next;
  logic [7:0] cal_reg, cal_next;
  logic [`TLT_IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  tlt_tx_cfg_s cfg_next;
  logic wr;
  logic [7:0] wb;
  always_comb begin
    wr = req_reg.sel & req_reg.write;
    wb = hwdata[7:0];
    cnt_high_next = cnt_high_reg;
    cnt_low_next = cnt_low_reg;
    trim_next = trim_reg;
    mask_next = mask_reg;
    if (wr && req_reg.index == `TLT_IDX_CNT_HIGH) cnt_high_next = wb;
    if (wr && req_reg.index == `TLT_IDX_CNT_LOW) cnt_low_next = wb;
    // unused trim bits are dropped on write so they always read back as zero
    if (wr && req_reg.index == `TLT_IDX_TRIM) begin
      trim_next = {wb[`TLT_TRIM_SEL_BIT:`TLT_TRIM_LO], `TLT_TRIM_PAD};
    end
    if (wr && req_reg.index == `TLT_IDX_IRQ_MASK) mask_next = wb[`TLT_IRQ_W-1:0];
    // restore wins over a write landing in the same cycle
    if (restore_defaults) begin
      cnt_high_next = `TLT_RST_BYTE;
      cnt_low_next = `TLT_RST_BYTE;
      trim_next = `TLT_RST_BYTE;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_high_reg <= `TLT_RST_BYTE;
      cnt_low_reg <= `TLT_RST_BYTE;
      trim_reg <= `TLT_RST_BYTE;
      mask_reg <= '0;
    end else begin
      cnt_high_reg <= cnt_high_next;
      cnt_low_reg <= cnt_low_next;
      trim_reg <= trim_next;
      mask_reg <= mask_next;
    end
  end
  // ----------------------------------------
  // display registers
  // ----------------------------------------
  // software writes never reach the displays; only the result pulses and restore-defaults load them
  always_comb begin
    rate_next = rate_reg;
    adc_next = adc_reg;
    cal_next = cal_reg;
    // rate display keeps only the upper nibble
    if (rate_valid) rate_next = {rate_code, `TLT_NIB_ZERO};
    if (adc_valid) adc_next = adc_value;
    if (cal_valid) cal_next = {cal_trim, cal_error, `TLT_TRIM_PAD};
    if (restore_defaults) begin
      rate_next = `TLT_RST_BYTE;
      adc_next = `TLT_RST_BYTE;
      cal_next = `TLT_RST_BYTE;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_reg <= `TLT_RST_BYTE;
      adc_reg <= `TLT_RST_BYTE;
      cal_reg <= `TLT_RST_BYTE;
    end else begin
      rate_reg <= rate_next;
      adc_reg <= adc_next;
      cal_reg <= cal_next;
    end
  end
  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[`TLT_IRQ_PAR] = wakeup_a_cmd & anticoll_ctl & card_idle
                     & (cnt_low_reg[`TLT_SPLIT_HI:0] != `TLT_SPLIT_NONE);
    ev[`TLT_IRQ_CAL] = cal_valid & cal_error;
    stat_next = stat_reg;
    if (wr && req_reg.index == `TLT_IDX_IRQ_STAT) stat_next = stat_reg & ~wb[`TLT_IRQ_W-1:0];
    // set after clear so a same-cycle event is never lost
    stat_next = stat_next | ev;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end
  // ----------------------------------------
  // transmit snapshot
  // ----------------------------------------
  always_comb begin
    cfg_next = tx_cfg;
    if (tx_start) begin
      // snapshot keeps an active frame stable against later writes
      cfg_next.full_bytes = {cnt_high_reg, cnt_low_reg[`TLT_CNT_LOW_HI:`TLT_CNT_LOW_LO]};
      cfg_next.split_bits = cnt_low_reg[`TLT_SPLIT_HI:0];
      cfg_next.bit_frame = iso_a_mode
                         & (cnt_low_reg[`TLT_SPLIT_HI:0] != `TLT_SPLIT_NONE);
      cfg_next.no_parity = cnt_low_reg[`TLT_SPLIT_HI:0] != `TLT_SPLIT_NONE;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cfg <= '0;
    end else begin
      tx_cfg <= cfg_next;
    end
  end
  assign irq = |(stat_reg & mask_reg);
  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic [31:0] rdata_reg, rdata_next;
  always_comb begin
    case (haddr[9:2])
      `TLT_IDX_CNT_HIGH: rd_byte = cnt_high_reg;
      `TLT_IDX_CNT_LOW: rd_byte = cnt_low_reg;
      `TLT_IDX_RATE: rd_byte = rate_reg;
      `TLT_IDX_ADC: rd_byte = adc_reg;
      `TLT_IDX_TRIM: rd_byte = trim_reg;
      `TLT_IDX_CAL_DISP: rd_byte = cal_reg;
      `TLT_IDX_IRQ_STAT: rd_byte = {6'h0, stat_reg};
      `TLT_IDX_IRQ_MASK: rd_byte = {6'h0, mask_reg};
      default: rd_byte = 8'h00;
    endcase
    rdata_next = (take && !hwrite) ? {24'h0, rd_byte} : rdata_reg;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ----------------------------------------
  // trim switches
  // ----------------------------------------
  tlt_trim_mux u_mux (
    .manual_sel(trim_reg[`TLT_TRIM_SEL_BIT]),
    .manual_code(trim_reg[`TLT_TRIM_HI:`TLT_TRIM_LO]),
    .cal_code(cal_reg[`TLT_CAL_HI:`TLT_CAL_LO]),
    .trim_pins_group_one(trim_pins_group_one),
    .trim_pins_group_two(trim_pins_group_two)
  );
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_trim_manual_path: assert property (trim_reg[7] |-> trim_pins_group_one == trim_reg[6:3]
    && trim_pins_group_two == trim_reg[6:3]) else $error("manual trim not on pins");
  a_trim_auto_path: assert property (!trim_reg[7] |-> trim_pins_group_two == cal_reg[7:4]
    && trim_pins_group_one == cal_reg[7:4]) else $error("auto trim not on pins");
  a_restore_clears: assert property (restore_defaults |=> cnt_high_reg == 8'h00
    && cnt_low_reg == 8'h00 && trim_reg == 8'h00) else $error("defaults not restored");
  a_display_clears: assert property (restore_defaults |=> rate_reg == 8'h00
    && adc_reg == 8'h00) else $error("displays not cleared");
  a_rate_low_zero: assert property (rate_reg[3:0] == 4'h0) else $error("rate low nibble set");
  a_adc_capture: assert property (adc_valid && !restore_defaults |=> adc_reg == $past(adc_value))
    else $error("adc result lost");
  a_parity_irq: assert property (anticoll_ctl && card_idle && wakeup_a_cmd
    && cnt_low_reg[2:0] != 3'h0 |=> stat_reg[0]) else $error("parity event lost");
  a_snap_count: assert property (tx_start |=> tx_cfg.full_bytes == {$past(cnt_high_reg),
    $past(cnt_low_reg[7:3])}) else $error("count snapshot wrong");
  a_snap_hold: assert property (!tx_start |=> $stable(tx_cfg)) else $error("snapshot moved");
  a_no_parity: assert property (tx_cfg.no_parity == (tx_cfg.split_bits != 3'h0))
    else $error("parity flag wrong");
  a_bit_frame: assert property (tx_cfg.bit_frame |-> tx_cfg.split_bits != 3'h0)
    else $error("bit frame with whole bytes");
  a_bit_frame_set: assert property (tx_start && iso_a_mode
    && cnt_low_reg[2:0] != 3'h0 |=> tx_cfg.bit_frame) else $error("bit frame not set");
  a_snap_split: assert property (tx_start
    |=> tx_cfg.split_bits == $past(cnt_low_reg[2:0])) else $error("split snapshot wrong");
  // ----------------------------------------
  // bus answer and write landing
  // ----------------------------------------
  // writes land at the data phase edge, so each check looks one edge after it
  a_ready_high: assert property (hreadyout) else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp) else $error("slave answered with an error");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> $stable(hrdata)) else $error("read data moved without a read");
  a_cnt_high_write: assert property (wr && req_reg.index == `TLT_IDX_CNT_HIGH
    && !restore_defaults |=> cnt_high_reg == $past(hwdata[7:0]))
    else $error("high count write lost");
  a_cnt_low_write: assert property (wr && req_reg.index == `TLT_IDX_CNT_LOW
    && !restore_defaults |=> cnt_low_reg == $past(hwdata[7:0]))
    else $error("low count write lost");
  a_trim_write: assert property (wr && req_reg.index == `TLT_IDX_TRIM
    && !restore_defaults |=> trim_reg == {$past(hwdata[7:3]), 3'h0})
    else $error("trim write lost");
  // ----------------------------------------
  // displays and interrupt status
  // ----------------------------------------
  a_rate_capture: assert property (rate_valid && !restore_defaults
    |=> rate_reg == {$past(rate_code), 4'h0}) else $error("rate result lost");
  a_rate_read_only: assert property (!rate_valid && !restore_defaults
    |=> $stable(rate_reg)) else $error("rate display moved");
  a_adc_read_only: assert property (!adc_valid && !restore_defaults
    |=> $stable(adc_reg)) else $error("converter display moved");
  a_cal_capture: assert property (cal_valid && !restore_defaults
    |=> cal_reg == {$past(cal_trim), $past(cal_error), 3'h0})
    else $error("calibration result lost");
  a_cal_clears: assert property (restore_defaults |=> cal_reg == 8'h00)
    else $error("calibration display not cleared");
  a_parity_sticky: assert property (stat_reg[0]
    && !(wr && req_reg.index == `TLT_IDX_IRQ_STAT && hwdata[0]) |=> stat_reg[0])
    else $error("parity status dropped");
  a_parity_quiet: assert property (!stat_reg[0] && !(anticoll_ctl && card_idle
    && wakeup_a_cmd && cnt_low_reg[2:0] != 3'h0) |=> !stat_reg[0])
    else $error("parity status set without cause");
  c_tx_split: cover property (tx_start ##1 tx_cfg.bit_frame);
  c_manual_trim: cover property (trim_reg[7] && trim_pins_group_one != 4'h0);
  c_irq_raise: cover property (!irq ##1 irq);
  c_restore: cover property (restore_defaults ##1 cnt_high_reg == 8'h00);
endmodule

/* File: logic/tlt_trim_mux.sv */
// Purpose: selects the source of the lc trim switches
// Assumes: both pin groups share one code
// Notes: purely combinational
module tlt_trim_mux
  import tlt_pkg::*;
(
  input wire logic manual_sel,
  input wire logic [3:0] manual_code,
  input wire logic [3:0] cal_code,
  output logic [3:0] trim_pins_group_one,
  output logic [3:0] trim_pins_group_two
);
  logic [3:0] code;
  always_comb begin
    code = manual_sel ? manual_code : cal_code;
    trim_pins_group_one = code;
    trim_pins_group_two = code;
  end
endmodule

/* File: shared/tlt_defs.svh */
// Purpose: register offsets, field positions, reset values for the tx length / trim block
// Assumes: byte address = 4 * printed register index
// Notes: definitions only
`ifndef TLT_DEFS_SVH
`define TLT_DEFS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define TLT_IDX_CNT_HIGH 8'h1d
`define TLT_IDX_CNT_LOW 8'h1e
`define TLT_IDX_RATE 8'h1f
`define TLT_IDX_ADC 8'h20
`define TLT_IDX_TRIM 8'h21
`define TLT_IDX_CAL_DISP 8'h23
`define TLT_IDX_IRQ_STAT 8'h30
`define TLT_IDX_IRQ_MASK 8'h31
// ----------------------------------------
// fields and resets
// ----------------------------------------
`define TLT_RST_BYTE 8'h00
`define TLT_SPLIT_NONE 3'h0
`define TLT_TRIM_SEL_BIT 7
`define TLT_TRIM_HI 6
`define TLT_TRIM_LO 3
`define TLT_CNT_LOW_HI 7
`define TLT_CNT_LOW_LO 3
`define TLT_SPLIT_HI 2
`define TLT_RATE_HI 7
`define TLT_RATE_LO 4
`define TLT_IRQ_PAR 0
`define TLT_IRQ_CAL 1
`define TLT_TRIM_PAD 3'h0
`define TLT_NIB_ZERO 4'h0
`define TLT_CAL_HI 7
`define TLT_CAL_LO 4
`define TLT_IRQ_W 2
`define TLT_OKAY 2'h0
`endif

/* File: shared/tlt_pkg.sv */
// Purpose: types for the tx length / trim register block
// Assumes: AHB-Lite slave with 32-bit data
// Notes: constants live in tlt_defs.svh
package tlt_pkg;
  typedef struct packed {
    logic [12:0] full_bytes;
    logic [2:0] split_bits;
    logic bit_frame;
    logic no_parity;
  } tlt_tx_cfg_s;
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] index;
  } tlt_req_s;
  typedef enum logic [2:0] {
    TLT_IDLE = 3'b001,
    TLT_WR = 3'b010,
    TLT_RD = 3'b100
  } tlt_phase_e;
endpackage
